// ===== core/pin_filter.sv
`timescale 1ns/100ps
`default_nettype none

// Synchronises and de-glitches the counter input pin
module pin_filter
    import tc_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic counter_input_pin_i,
    pin_if.filt       pin
);

    logic       sync1;      // First synchroniser stage
    logic       sync2;      // Second synchroniser stage
    logic [3:0] stable;     // Cycles the new level has held
    logic       level;      // Accepted level
    logic       next_level; // Level after this cycle
    logic       differs;    // Synchronised pin disagrees with level
    logic       accept;     // Filter lets the new level through

    assign differs    = sync2 != level;
    // Long enough run wins; slow clocking bypasses the filter
    assign accept     = differs & (pin.slow_mode |
                        (stable == FILT_THRESH - 4'h1));
    assign next_level = accept ? sync2 : level;

    // Two-stage synchroniser
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
        end else begin
            sync1 <= counter_input_pin_i;
            sync2 <= sync1;
        end
    end

    // Run-length counter and edge outputs
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stable    <= 4'h0;
            level     <= 1'b0;
            pin.rise  <= 1'b0;
            pin.fall  <= 1'b0;
        end else begin
            stable    <= (differs & ~accept) ? stable + 4'h1 : 4'h0;
            level     <= next_level;
            pin.rise  <= next_level & ~level;
            pin.fall  <= ~next_level & level;
        end
    end

    assign pin.level = level;

    a_filter_bypass: assert property (
        @(posedge clk_i) disable iff (rst_i)
        pin.slow_mode && differs |=> level == $past(sync2))
        else $error("filter not bypassed in slow clocking");

endmodule : pin_filter

`default_nettype wire

// ===== core/pin_if.sv
`timescale 1ns/100ps
`default_nettype none

// Filtered counter input pin shared between filter and counter
interface pin_if;
    logic slow_mode; // Bypass the noise filter
    logic level;     // Filtered pin level
    logic rise;      // One-cycle rising edge
    logic fall;      // One-cycle falling edge

    modport filt (input slow_mode, output level, rise, fall);
    modport user (output slow_mode, input level, rise, fall);
endinterface : pin_if

`default_nettype wire

// ===== core/tc_pkg.sv
package tc_pkg;

    // Register byte offsets on the bus
    localparam logic [4:0]  OFS_CTRL       = 5'h00; // Control register
    localparam logic [4:0]  OFS_CMPA       = 5'h04; // Compare register A
    localparam logic [4:0]  OFS_CAPB       = 5'h08; // Compare/capture register B
    localparam logic [4:0]  OFS_PWR        = 5'h0c; // Clock mode and stop entry
    localparam logic [4:0]  OFS_STAT       = 5'h10; // Live state, read only

    // Control register fields and reset value
    localparam int          CTRL_MODE_LSB  = 0;     // Operating mode select
    localparam int          CTRL_SRC_LSB   = 2;     // Source clock select
    localparam int          CTRL_START_LSB = 4;     // Start control
    localparam int          CTRL_OPT_BIT   = 6;     // Capture or stop option
    localparam logic [7:0]  CTRL_RESET     = 8'h00; // Stopped after reset

    // Power register fields and reset value
    localparam int          PWR_SLOW_BIT   = 0;     // Slow or sleep clocking
    localparam int          PWR_TAP_BIT    = 1;     // Prescaler tap select
    localparam int          PWR_STOP_BIT   = 2;     // Write 1: enter stop mode
    localparam logic [1:0]  PWR_RESET      = 2'h0;  // Normal clocking

    // Compare register reset value
    localparam logic [15:0] CMP_RESET      = 16'hffff;

    // Field encodings
    localparam logic [1:0]  MODE_BASIC     = 2'b00; // Timer, trigger, event
    localparam logic [1:0]  SRC_DEEP       = 2'b00; // Deep prescaler tap
    localparam logic [1:0]  SRC_MID        = 2'b01; // Clock over 2^7
    localparam logic [1:0]  SRC_FAST       = 2'b10; // Clock over 2^3
    localparam logic [1:0]  SRC_PIN        = 2'b11; // External pin
    localparam logic [1:0]  START_STOP     = 2'b00; // Stop and clear
    localparam logic [1:0]  START_CMD      = 2'b01; // Command start
    localparam logic [1:0]  START_RISE     = 2'b10; // Rising edge
    localparam logic [1:0]  START_FALL     = 2'b11; // Falling edge

    // Prescaler taps, as powers of two
    localparam int          DIV_W          = 11;    // Prescaler width
    localparam int          DIV_DEEP       = 11;    // System clock over 2^11
    localparam int          DIV_MID        = 7;     // System clock over 2^7
    localparam int          DIV_FAST       = 3;     // System clock over 2^3
    localparam int          FS_DIV         = 3;     // Low clock over 2^3

    // Pin noise filter, in periods of the system clock
    localparam int          FILT_REJECT_FC = 4;     // Always rejected
    localparam int          FILT_ACCEPT_FC = 12;    // Always accepted
    localparam logic [3:0]  FILT_THRESH    =
        4'((FILT_REJECT_FC + FILT_ACCEPT_FC) / 2);

    // Counter state
    typedef enum logic [1:0] {st_stop, st_wait, st_run} run_state_t;

endpackage : tc_pkg

// ===== core/timer_counter.sv
// Notes on behaviour
// - Timer mode counts source ticks, pin rising edges when the pin source is selected
// - Timer match with A: interrupt, clear, continue
// - Capture enable copies count into B per tick
// - Trigger mode holds counter until trigger edge
// - Stop option: opposite edge halts, no interrupt
// - Trigger mode match: clear, halt, interrupt
// - Halted counter restarts from zero on trigger
// - Without option, opposite and repeat edges ignored
// - Filter rejects 4 clocks, accepts 12 clocks
// - Slow clocking bypasses the pin filter
// - Event mode counts selected pin edges
// - Event match checked on opposite edge
// - Capture also works in event mode
// - Source select picks prescaler tap or pin
// - Mode select 00 is timer, trigger, event
// - Compare value commits after upper byte, next tick
// - Stop mode entry forces start control to 00
//
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none

module timer_counter
    import tc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [4:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    input  wire logic [3:0]  byteenable_i,
    output var  logic [31:0] readdata_o,
    output logic             waitrequest_o,
    input  wire logic        counter_input_pin_i,
    input  wire logic        low_clock_i,
    output var  logic        timer_interrupt_o
);

    pin_if pin ();                       // Filtered pin edges

    logic [7:0]    ctrl;                 // Control register
    logic [1:0]    pwr;                  // Slow mode and tap select
    logic [15:0]   count;                // Up-counter
    logic [15:0]   next_count;           // Counter after this cycle
    run_state_t    state;                // Counter state
    run_state_t    next_state;           // State after this cycle
    logic          next_irq;             // Interrupt this cycle
    logic [DIV_W-1:0] div;               // Free prescaler
    logic          fs_s1;                // Low clock sync stage 1
    logic          fs_s2;                // Low clock sync stage 2
    logic          fs_s3;                // Low clock edge history
    logic [2:0]    fs_cnt;               // Low clock divider
    logic          ack;                  // Bus answer cycle
    logic [7:0]    cmp_lo   [2];         // Lower byte holding
    logic [15:0]   cmp_stage[2];         // Value awaiting a tick
    logic          cmp_pend [2];         // Staged value not yet live
    logic [15:0]   cmp_val  [2];         // Live compare values

    // Bus decode
    wire           bus_busy = read_i | write_i;
    wire           wr_ok    = write_i & ack;
    wire           wr_ctrl  = wr_ok & (address_i == OFS_CTRL) &
                              byteenable_i[0];
    wire           wr_pwr   = wr_ok & (address_i == OFS_PWR) &
                              byteenable_i[0];
    wire           stop_req = wr_pwr & writedata_i[PWR_STOP_BIT];
    wire           wr_cmp[2];
    assign wr_cmp[0] = wr_ok & (address_i == OFS_CMPA);
    assign wr_cmp[1] = wr_ok & (address_i == OFS_CAPB);

    // Control and power field views
    wire [1:0]     mode_sel  = ctrl[CTRL_MODE_LSB +: 2];
    wire [1:0]     src_sel   = ctrl[CTRL_SRC_LSB +: 2];
    wire [1:0]     start_sel = ctrl[CTRL_START_LSB +: 2];
    wire           option    = ctrl[CTRL_OPT_BIT];
    wire           slow_mode = pwr[PWR_SLOW_BIT];
    wire           tap_sel   = pwr[PWR_TAP_BIT];

    // Mode decode; other modes hold the counter stopped
    wire           mode_ok  = mode_sel == MODE_BASIC;
    wire           is_timer = mode_ok & (start_sel == START_CMD);
    wire           is_event = mode_ok & start_sel[1] & (src_sel == SRC_PIN);
    wire           is_ext   = mode_ok & start_sel[1] & (src_sel != SRC_PIN);

    // Selected and opposite pin edges
    wire           sel_edge = (start_sel == START_FALL) ? pin.fall
                                                        : pin.rise;
    wire           opp_edge = (start_sel == START_FALL) ? pin.rise
                                                        : pin.fall;

    // Prescaler taps and source tick
    wire           fs_rise   = fs_s2 & ~fs_s3;
    wire           fs_tick   = fs_rise & (&fs_cnt);
    wire           deep_tick = (slow_mode | tap_sel) ? fs_tick
                                : &div[DIV_DEEP-1:0];
    wire           mid_tick  = ~slow_mode & (&div[DIV_MID-1:0]);
    wire           fast_tick = ~slow_mode & (&div[DIV_FAST-1:0]);
    wire           src_tick  = (src_sel == SRC_DEEP) ? deep_tick
                             : (src_sel == SRC_MID)  ? mid_tick
                             : (src_sel == SRC_FAST) ? fast_tick
                             : sel_edge;
    wire           match     = count == cmp_val[0];
    wire           capture   = option & (is_timer | is_event) &
                               (state == st_run) & src_tick;

    // Read data selection
    wire [31:0]    rd_mux =
          (address_i == OFS_CTRL) ? {24'h0, ctrl}
        : (address_i == OFS_CMPA) ? {16'h0, cmp_val[0]}
        : (address_i == OFS_CAPB) ? {16'h0, cmp_val[1]}
        : (address_i == OFS_PWR)  ? {30'h0, pwr}
        : (address_i == OFS_STAT) ? {28'h0, cmp_pend[1], cmp_pend[0],
                                     state == st_run, state == st_wait}
        : 32'h0;

    assign waitrequest_o  = bus_busy & ~ack;
    assign pin.slow_mode  = slow_mode;

    pin_filter u_filter (
        .clk_i               (clk_i),
        .rst_i               (rst_i),
        .counter_input_pin_i (counter_input_pin_i),
        .pin                 (pin)
    );

    // One wait cycle, then answer
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack        <= 1'b0;
            readdata_o <= 32'h0;
        end else begin
            ack        <= bus_busy & ~ack;
            if (read_i & ~ack) begin
                readdata_o <= rd_mux;
            end
        end
    end

    // Control and power registers; stop entry wins
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl <= CTRL_RESET;
            pwr  <= PWR_RESET;
        end else begin
            if (stop_req) begin
                ctrl[CTRL_START_LSB +: 2] <= START_STOP;
            end else if (wr_ctrl) begin
                ctrl <= writedata_i[7:0];
            end
            if (wr_pwr) begin
                pwr <= writedata_i[1:0];
            end
        end
    end

    // Prescaler and low clock divider
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div    <= '0;
            fs_s1  <= 1'b0;
            fs_s2  <= 1'b0;
            fs_s3  <= 1'b0;
            fs_cnt <= 3'h0;
        end else begin
            div    <= div + 11'h001;
            fs_s1  <= low_clock_i;
            fs_s2  <= fs_s1;
            fs_s3  <= fs_s2;
            fs_cnt <= fs_rise ? fs_cnt + 3'h1 : fs_cnt;
        end
    end

    // Compare registers, staged until the next source tick
    for (genvar gi = 0; gi < 2; gi++) begin : g_cmp
        wire hi_wr = wr_cmp[gi] & byteenable_i[1];
        wire [7:0] lo_new = byteenable_i[0] ? writedata_i[7:0]
                                            : cmp_lo[gi];
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                cmp_lo[gi]    <= CMP_RESET[7:0];
                cmp_stage[gi] <= CMP_RESET;
                cmp_pend[gi]  <= 1'b0;
                cmp_val[gi]   <= CMP_RESET;
            end else begin
                cmp_lo[gi] <= wr_cmp[gi] ? lo_new : cmp_lo[gi];
                if (hi_wr) begin
                    cmp_stage[gi] <= {writedata_i[15:8], lo_new};
                end
                // A new upper byte write outranks the commit
                cmp_pend[gi] <= hi_wr | (cmp_pend[gi] & ~src_tick);
                if (gi == 1 && capture) begin
                    cmp_val[gi] <= count;
                end else if (cmp_pend[gi] & src_tick) begin
                    cmp_val[gi] <= cmp_stage[gi];
                end
            end
        end
    end

    // Counter sequencing
    always_comb begin
        next_state = state;
        next_count = count;
        next_irq   = 1'b0;
        case (state)
            st_stop: begin
                if (is_timer | is_event) begin
                    next_state = st_run;
                end else if (is_ext) begin
                    next_state = st_wait;
                end
            end
            st_wait: begin
                // Held at zero until the trigger edge
                next_count = 16'h0000;
                if (sel_edge) begin
                    next_state = st_run;
                end
            end
            default: begin
                if (is_timer) begin
                    // Source ticks; pin rising edges when SRC_PIN is selected
                    if (src_tick & match) begin
                        next_count = 16'h0000;
                        next_irq   = 1'b1;
                    end else if (src_tick) begin
                        next_count = count + 16'h0001;
                    end
                end else if (is_ext) begin
                    // Repeated trigger edges are ignored
                    if (src_tick & match) begin
                        next_count = 16'h0000;
                        next_irq   = 1'b1;
                        next_state = st_wait;
                    end else if (option & opp_edge) begin
                        next_count = 16'h0000;
                        next_state = st_wait;
                    end else if (src_tick) begin
                        next_count = count + 16'h0001;
                    end
                end else begin
                    if (opp_edge & match) begin
                        next_count = 16'h0000;
                        next_irq   = 1'b1;
                    end else if (sel_edge) begin
                        next_count = count + 16'h0001;
                    end
                end
            end
        endcase
        // Stop control or another mode clears the counter
        if (!(is_timer | is_event | is_ext)) begin
            next_state = st_stop;
            next_count = 16'h0000;
        end
    end

    // Counter state registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state             <= st_stop;
            count             <= 16'h0000;
            timer_interrupt_o <= 1'b0;
        end else begin
            state             <= next_state;
            count             <= next_count;
            timer_interrupt_o <= next_irq;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_timer_advance: assert property (
        state == st_run && is_timer && src_tick && !match
        |=> count == $past(count) + 16'h0001)
        else $error("timer did not advance on tick");
    a_timer_match: assert property (
        state == st_run && is_timer && src_tick && match
        |=> count == 16'h0000 && timer_interrupt_o)
        else $error("timer match did not clear and interrupt");
    a_capture_copy: assert property (
        capture |=> cmp_val[1] == $past(count))
        else $error("capture missed the live count");
    a_trig_hold: assert property (
        state == st_wait && is_ext && !sel_edge
        |=> count == 16'h0000 && state == st_wait)
        else $error("counter moved before trigger");
    a_opp_halt: assert property (
        state == st_run && is_ext && option && opp_edge &&
        !(src_tick && match)
        |=> state == st_wait && !timer_interrupt_o && count == 16'h0000)
        else $error("opposite edge did not halt quietly");
    a_ext_match: assert property (
        state == st_run && is_ext && src_tick && match
        |=> state == st_wait && timer_interrupt_o)
        else $error("trigger match did not halt with interrupt");
    a_event_count: assert property (
        state == st_run && is_event && sel_edge
        |=> count == $past(count) + 16'h0001)
        else $error("event edge not counted");
    a_event_match: assert property (
        state == st_run && is_event && opp_edge && match
        |=> timer_interrupt_o ##1 !timer_interrupt_o)
        else $error("event match interrupt wrong");
    a_irq_clears: assert property (
        timer_interrupt_o |-> count == 16'h0000)
        else $error("interrupt without counter clear");
    a_low_byte_only: assert property (
        wr_cmp[0] && !byteenable_i[1] && !cmp_pend[0]
        |=> $stable(cmp_val[0]))
        else $error("lower byte write changed compare value");
    a_stop_entry: assert property (
        stop_req |=> start_sel == START_STOP ##1 state == st_stop)
        else $error("stop entry did not stop the timer");

    c_timer_irq: cover property (is_timer && timer_interrupt_o);
    c_ext_quiet: cover property (is_ext && option && opp_edge &&
                                 state == st_run);
    c_event_irq: cover property (is_event && timer_interrupt_o);
    c_capture:   cover property (capture);

endmodule : timer_counter

`default_nettype wire

// ===== test/pulse_src.sv
`timescale 1ns/100ps
`default_nettype none

// Behavioural pulse source standing on the counter input pin
module pulse_src (
    input  wire logic clk_i,
    output var  logic pin_o
);
    // Pin rests low until the first level is asked for
    initial pin_o = 1'b0;

    // Drive one level just after an edge and hold it for n cycles
    task automatic level(input logic v, input int n);
        pin_o <= v; // Each level held n cycles, as few as one
        repeat (n) @(posedge clk_i);
    endtask : level
endmodule : pulse_src

`default_nettype wire

// ===== test/tb_timer_counter_trigger_event_modes.sv
`timescale 1ns/100ps
`default_nettype none

module tb_timer_counter_trigger_event_modes
    import tc_pkg::*;
;
    logic        clk_i = 1'b0;     // System clock, 10 MHz
    logic        rst_i = 1'b1;     // Reset, active high
    logic [4:0]  address_i = '0;   // Bus address
    logic        read_i = 1'b0;    // Bus read
    logic        write_i = 1'b0;   // Bus write
    logic [31:0] writedata_i = '0; // Bus write data
    logic [3:0]  byteenable_i = '0; // Bus byte lanes
    logic [31:0] readdata_o;       // Bus read data
    logic        waitrequest_o;    // Bus stall
    logic        pin;              // Counter input pin
    logic [3:0]  low_div = '0;     // Low clock, fc over 16
    logic        timer_interrupt_o; // Interrupt pulse
    logic        irq_prev = 1'b0;  // Interrupt one cycle back
    logic [31:0] last_rd;          // Last read word
    logic [31:0] exp_q[$];         // Expected read words
    logic [31:0] msk_q[$];         // Bits that matter
    logic [15:0] lfsr_v = 16'h8181; // Random state
    logic [1:0]  srcs[3] = '{SRC_FAST, SRC_MID, SRC_DEEP};
    int          divs[3] = '{DIV_FAST, DIV_MID, DIV_DEEP};
    int          mismatches = 0;   // Failed comparisons
    int          compares = 0;     // All comparisons
    int          cyc = 0;          // Cycle count
    int          irq_cnt = 0;      // Interrupt pulses seen
    int          irq_at = 0;       // Cycle of last pulse
    int          n0, t0;           // Scenario marks

    // Clock generator
    initial forever #50 clk_i = ~clk_i;

    // Low clock, a sixteenth of the system clock
    always @(posedge clk_i) low_div <= low_div + 4'h1;

    timer_counter u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .address_i(address_i),
        .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
        .byteenable_i(byteenable_i), .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o), .counter_input_pin_i(pin),
        .low_clock_i(low_div[3]), .timer_interrupt_o(timer_interrupt_o)
    );

    pulse_src u_src (.clk_i(clk_i), .pin_o(pin));

    // Next random value
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr

    // Control word in the basic mode
    function automatic logic [31:0] cw(input logic o, input logic [1:0] st,
                                       input logic [1:0] src);
        return 32'({o, st, src, MODE_BASIC});
    endfunction : cw

    // Count and report one comparison
    task automatic check(input string what, input logic [31:0] e,
                         input logic [31:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : check

    // One bus transfer, held until the stall drops
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        @(posedge clk_i);
        read_i <= ~w;
        write_i <= w;
        address_i <= a;
        writedata_i <= d;
        byteenable_i <= be;
        do @(posedge clk_i); while (waitrequest_o !== 1'b0);
        read_i <= 1'b0;
        write_i <= 1'b0;
    endtask : bus

    // Register write
    task automatic wr(input logic [4:0] a, input logic [31:0] d,
                      input logic [3:0] be);
        bus(1'b1, a, d, be);
    endtask : wr

    // Register read with its expectation noted first
    task automatic rd(input logic [4:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(1'b0, a, 32'h0, 4'hf);
    endtask : rd

    // Stop, load compare A, let it commit, then start
    task automatic setup(input logic [15:0] a, input logic [31:0] c);
        wr(OFS_CTRL, cw(1'b0, START_STOP, SRC_FAST), 4'h1);
        wr(OFS_CMPA, 32'(a), 4'h3);
        repeat (16) @(posedge clk_i);
        wr(OFS_CTRL, c, 4'h1);
    endtask : setup

    // Wait for the next interrupt pulse, bounded
    task automatic wait_irq(input int limit);
        int n;
        n = irq_cnt;
        repeat (limit) begin
            @(posedge clk_i);
            if (irq_cnt != n) break;
        end
        check("irq arrival", 32'h1, 32'(irq_cnt != n));
    endtask : wait_irq

    // Print counts and verdict, then stop
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    // Monitor: read results against notes, interrupt pulses
    always @(negedge clk_i) begin
        cyc++;
        if (read_i && waitrequest_o === 1'b0 && exp_q.size() > 0) begin
            last_rd = readdata_o;
            check("readdata", exp_q[0] & msk_q[0], readdata_o & msk_q[0]);
            exp_q.delete(0);
            msk_q.delete(0);
        end
        if (timer_interrupt_o === 1'b1) begin
            irq_cnt++;
            irq_at = cyc;
            check("irq width", 32'h0, 32'(irq_prev));
        end
        irq_prev = timer_interrupt_o;
    end

    // Watchdog against a hang
    initial begin
        repeat (40000) @(posedge clk_i);
        mismatches++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFS_CTRL, 32'(CTRL_RESET), '1);
        rd(OFS_CMPA, 32'(CMP_RESET), '1);
        rd(OFS_CAPB, 32'(CMP_RESET), '1);
        rd(OFS_PWR, 32'(PWR_RESET), '1);
        rd(5'h14, 32'h0, '1);
        // Timer period per source tap, with pin activity meanwhile
        foreach (srcs[i]) begin
            setup(16'h3, cw(1'b0, START_CMD, srcs[i]));
            fork
                begin
                    u_src.level(1'b1, 20);
                    u_src.level(1'b0, 20);
                end
            join_none
            wait_irq(16 << divs[i]);
            t0 = irq_at;
            wait_irq(16 << divs[i]);
            check("period", 32'(4 << divs[i]), 32'(irq_at - t0));
        end
        // Tap select: low clock over 2^3 per tick
        wr(OFS_PWR, 32'h2, 4'h1);
        setup(16'h3, cw(1'b0, START_CMD, SRC_DEEP));
        wait_irq(4096);
        t0 = irq_at;
        wait_irq(4096);
        check("fs period", 32'(4 << (FS_DIV + 4)), 32'(irq_at - t0));
        // Mode other than 00 keeps the counter stopped
        setup(16'h3, cw(1'b0, START_CMD, SRC_FAST) | 32'h1);
        n0 = irq_cnt;
        repeat (200) @(posedge clk_i);
        check("irq in mode 01", 32'(n0), 32'(irq_cnt));
        // Capture into B, low byte only write to A
        setup(16'h00ff, cw(1'b1, START_CMD, SRC_FAST));
        repeat (16) @(posedge clk_i);
        rd(OFS_CAPB, 32'h0, 32'h0);
        t0 = int'(last_rd[15:0]);
        repeat (61) @(posedge clk_i);
        rd(OFS_CAPB, 32'(t0 + 8), '1);
        wr(OFS_CMPA, 32'h0011, 4'h1);
        repeat (16) @(posedge clk_i);
        rd(OFS_CMPA, 32'h00ff, 32'hffff);
        // Trigger mode, stop on opposite edge
        setup(16'h14, cw(1'b1, START_RISE, SRC_FAST));
        n0 = irq_cnt;
        u_src.level(1'b1, 20);
        u_src.level(1'b0, 300);
        check("short trigger", 32'(n0), 32'(irq_cnt));
        repeat (2) begin
            u_src.level(1'b1, 300);
            u_src.level(1'b0, 300);
        end
        check("long triggers", 32'(n0 + 2), 32'(irq_cnt));
        // Trigger mode, opposite and repeated edges ignored
        setup(16'h14, cw(1'b0, START_RISE, SRC_FAST));
        n0 = irq_cnt;
        t0 = cyc;
        u_src.level(1'b1, 20);
        u_src.level(1'b0, 20);
        u_src.level(1'b1, 300);
        u_src.level(1'b0, 300);
        check("one irq", 32'(n0 + 1), 32'(irq_cnt));
        check("irq delay", 32'h1,
              32'((irq_at - t0) >= 160 && (irq_at - t0) <= 200));
        // Event counter with capture, match on opposite edge
        setup(16'h2, cw(1'b1, START_RISE, SRC_PIN));
        n0 = irq_cnt;
        u_src.level(1'b1, 12);
        u_src.level(1'b0, 20);
        u_src.level(1'b1, 20);
        rd(OFS_CAPB, 32'h1, 32'hffff);
        check("irq on count edge", 32'(n0), 32'(irq_cnt));
        u_src.level(1'b0, 30);
        check("irq on opposite edge", 32'(n0 + 1), 32'(irq_cnt));
        // Short random glitches rejected, full pulses counted
        repeat (8) begin
            lfsr_v = lfsr(lfsr_v);
            u_src.level(1'b1, int'(lfsr_v[1:0]) + 1);
            u_src.level(1'b0, 20);
        end
        check("glitches", 32'(n0 + 1), 32'(irq_cnt));
        repeat (2) begin
            u_src.level(1'b1, 12);
            u_src.level(1'b0, 20);
        end
        check("full pulses", 32'(n0 + 2), 32'(irq_cnt));
        // Slow clocking lets short pulses through
        wr(OFS_PWR, 32'h1, 4'h1);
        repeat (2) begin
            u_src.level(1'b1, 4);
            u_src.level(1'b0, 8);
        end
        check("slow pulses", 32'(n0 + 3), 32'(irq_cnt));
        // Stop mode entry clears the start field
        wr(OFS_PWR, 32'h4, 4'h1);
        rd(OFS_CTRL, cw(1'b1, START_STOP, SRC_PIN), 32'hff);
        tally_and_finish();
    end
endmodule : tb_timer_counter_trigger_event_modes

`default_nettype wire
